// ### psd_defs.svh
// offsets, field positions, reset values and timing counts of the
// phase shedding / load line configuration bank
// assumes a 50 MHz core clock
`ifndef PSD_DEFS_SVH
`define PSD_DEFS_SVH

// command codes
`define PSD_CMD_PHASE_NUMBER 8'hd0
`define PSD_CMD_SHED_LIMITS 8'hd1
`define PSD_CMD_LOW_POWER 8'hd2
`define PSD_CMD_LOAD_LINE 8'hd3
`define PSD_CMD_FEATURES 8'hd4
`define PSD_CMD_PWM_MID 8'hd5
`define PSD_CMD_LOCK 8'hd6
`define PSD_CMD_RISE_TUNE 8'hd7

// register widths
`define PSD_W_PHASE 3
`define PSD_W_SHED 8
`define PSD_W_LOW_POWER 10
`define PSD_W_LOAD_LINE 7
`define PSD_W_FEATURES 7
`define PSD_W_PWM_MID 2
`define PSD_W_LOCK 2
`define PSD_W_RISE 14

// reset values
`define PSD_RST_PHASE 3'h0
`define PSD_RST_SHED 8'h00
`define PSD_RST_LOW_POWER 10'h0c0
`define PSD_RST_LOAD_LINE 7'h00
`define PSD_RST_FEATURES 7'h00
`define PSD_RST_PWM_MID 2'h0
`define PSD_RST_LOCK 2'h0
`define PSD_RST_RISE 14'h0000

// field positions
`define PSD_F_NMIN 1:0
`define PSD_F_KFAC 3:2
`define PSD_F_HYS 5:4
`define PSD_F_I1 7:6
`define PSD_F_LPPS 1:0
`define PSD_F_DROP 3:2
`define PSD_F_FLIM 5:4
`define PSD_F_APA_TC 7:6
`define PSD_F_APA_DLY 9:8
`define PSD_B_DROOP 0
`define PSD_F_NEG_LL 3:1
`define PSD_B_POS_LL 4
`define PSD_F_POS_RANGE 6:5
`define PSD_B_BOOT 0
`define PSD_B_DIODE 1
`define PSD_B_AUTO 2
`define PSD_B_DITHER 3
`define PSD_F_APA_LVL 6:4
`define PSD_B_MID 0
`define PSD_F_RISE_OFS 5:0

// timing figures and derived counts
`define PSD_CLK_MHZ 50
`define PSD_DROP0_US 4600
`define PSD_DROP1_US 2300
`define PSD_DROP2_US 1200
`define PSD_DROP3_US 600
`define PSD_APA_STEP_NS 100
`define PSD_APA_STEP_CYC ((`PSD_APA_STEP_NS * `PSD_CLK_MHZ + 999) / 1000)
`define PSD_DITHER_KHZ 15
`define PSD_APA_LVL_MV 10
`define PSD_RISE_STEP_MV 5

`endif

// ### psd_pkg.sv
// types of the phase shedding / load line configuration bank
// constants live in psd_defs.svh
package psd_pkg;

    // nonvolatile image loaded as one unit
    typedef struct packed {
        logic [7:0] shed;
        logic [9:0] low_power;
        logic [6:0] load_line;
        logic [6:0] features;
        logic [1:0] pwm_mid;
        logic [13:0] rise;
    } psd_nvm_type;

    // decoded settings seen by the control loop
    typedef struct packed {
        logic [2:0] min_phases;      // 1..4
        logic [7:0] k_factor_x100;   // 100..175
        logic [9:0] hys_pct_x10;     // 125..500
        logic [7:0] i1_pct;          // 80..110
        logic [1:0] low_power_mode;
        logic [2:0] low_power_phases;
        logic [1:0] freq_cap_code;   // 0 x2, 1 x1.5, 2 none
        logic [3:0] apa_tc_div;      // 1,2,4,8
        logic [8:0] apa_delay_ns;
        logic [3:0] apa_delay_cyc;
        logic droop_en;
        logic [6:0] neg_ll_pct;
        logic pos_ll_en;
        logic [5:0] pos_ll_mv;
        logic boot_refresh_on;
        logic diode_emul_en;
        logic auto_shed_en;
        logic [6:0] apa_level_mv;
        logic mid_level_5v;
        logic allow_vid;
        logic allow_small_ofs;
        logic allow_large_ofs;
        logic [8:0] rise_offset_mv;
    } psd_cfg_type;

    typedef enum logic [1:0] {
        PSD_DITH_LOW = 2'b00,
        PSD_DITH_MID = 2'b01,
        PSD_DITH_HIGH = 2'b10
    } psd_dither_type;

endpackage

// ### psd_config_bank.sv
// configuration command bank: shedding, phase adding, load line,
// feature enables, pwm mid level, voltage lock, rising offset
// assumes a command decoder on the management bus hands over one
// whole command per strobe, all inputs but ref_low_pin_i and
// shed_pin_i come from logic on mclk_i
`timescale 1ns/10ps
`include "psd_defs.svh"

module psd_config_bank #(
    parameter int DROP0_CYC = `PSD_DROP0_US * `PSD_CLK_MHZ,
    parameter int DROP1_CYC = `PSD_DROP1_US * `PSD_CLK_MHZ,
    parameter int DROP2_CYC = `PSD_DROP2_US * `PSD_CLK_MHZ,
    parameter int DROP3_CYC = `PSD_DROP3_US * `PSD_CLK_MHZ
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // command port
    input wire logic [7:0] cmd_code_i,
    input wire logic cmd_wr_i,
    input wire logic cmd_rd_i,
    input wire logic [15:0] cmd_wdata_i,
    output logic [15:0] cmd_rdata_o,
    output logic cmd_rvalid_o,
    output logic cmd_hit_o,
    // nonvolatile bank load and pins
    input wire logic nvm_load_i,
    input wire psd_pkg::psd_nvm_type nvm_image_i,
    input wire logic [3:0] shed_pin_i,
    input wire logic ref_low_pin_i,
    // control loop side
    input wire logic [2:0] oper_phases_i,
    input wire logic shed_req_i,
    input wire logic sw_tick_i,
    output logic shed_grant_o,
    output logic [2:0] phase_number_o,
    output logic signed [7:0] dither_khz_o,
    output psd_pkg::psd_cfg_type cfg_o
);

    logic [2:0] phase_reg, phase_next;
    logic [7:0] shed_reg, shed_next;
    logic [9:0] lp_reg, lp_next;
    logic [6:0] ll_reg, ll_next;
    logic [6:0] feat_reg, feat_next;
    logic [1:0] mid_reg, mid_next;
    logic [1:0] lock_reg, lock_next;
    logic [13:0] rise_reg, rise_next;
    logic [15:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic [17:0] drop_cnt_reg, drop_cnt_next;
    logic grant_reg, grant_next;
    psd_pkg::psd_dither_type dith_reg, dith_next;
    logic signed [7:0] dkhz_reg, dkhz_next;
    psd_pkg::psd_cfg_type cfg_reg, cfg_next;
    logic [4:0] pin_s1_reg, pin_s2_reg;
    logic hit;

    // pins from the analog side pass two flops before use
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pin_s1_reg <= 5'h00;
            pin_s2_reg <= 5'h00;
        end
        else
        begin
            pin_s1_reg <= {ref_low_pin_i, shed_pin_i};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // command decode
    always_comb
    begin
        case (cmd_code_i)
            `PSD_CMD_PHASE_NUMBER, `PSD_CMD_SHED_LIMITS,
            `PSD_CMD_LOW_POWER, `PSD_CMD_LOAD_LINE,
            `PSD_CMD_FEATURES, `PSD_CMD_PWM_MID,
            `PSD_CMD_LOCK, `PSD_CMD_RISE_TUNE: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    assign cmd_hit_o = hit;

    // register writes; a bank load wins over a host write in the same
    // cycle since it restores a whole consistent set
    always_comb
    begin
        phase_next = phase_reg;
        shed_next = shed_reg;
        lp_next = lp_reg;
        ll_next = ll_reg;
        feat_next = feat_reg;
        mid_next = mid_reg;
        lock_next = lock_reg;
        rise_next = rise_reg;
        if (nvm_load_i)
        begin
            shed_next = nvm_image_i.shed;
            // minimum phase follows the low power phase count
            shed_next[`PSD_F_NMIN] = {1'b0, nvm_image_i.low_power[0]};
            // k and hysteresis come from the shedding pin
            shed_next[`PSD_F_KFAC] = pin_s2_reg[1:0];
            shed_next[`PSD_F_HYS] = pin_s2_reg[3:2];
            lp_next = nvm_image_i.low_power;
            ll_next = nvm_image_i.load_line;
            feat_next = nvm_image_i.features;
            mid_next = nvm_image_i.pwm_mid;
            rise_next = nvm_image_i.rise;
        end
        else if (cmd_wr_i)
        begin
            // high bits beyond each width are dropped
            case (cmd_code_i)
                `PSD_CMD_PHASE_NUMBER:
                    if (!feat_reg[`PSD_B_AUTO]) // refused under auto
                        phase_next = cmd_wdata_i[2:0];
                `PSD_CMD_SHED_LIMITS: shed_next = cmd_wdata_i[7:0];
                `PSD_CMD_LOW_POWER: lp_next = cmd_wdata_i[9:0];
                `PSD_CMD_LOAD_LINE: ll_next = cmd_wdata_i[6:0];
                `PSD_CMD_FEATURES: feat_next = cmd_wdata_i[6:0];
                `PSD_CMD_PWM_MID: mid_next = cmd_wdata_i[1:0];
                `PSD_CMD_LOCK: lock_next = cmd_wdata_i[1:0];
                `PSD_CMD_RISE_TUNE: rise_next = cmd_wdata_i[13:0];
                default: phase_next = phase_reg;
            endcase
        end
    end

    // read path, registered, unmapped codes return zero
    always_comb
    begin
        rvalid_next = cmd_rd_i;
        rdata_next = rdata_reg;
        if (cmd_rd_i)
        begin
            case (cmd_code_i)
                `PSD_CMD_PHASE_NUMBER:
                    rdata_next = {13'h0000, phase_number_o};
                `PSD_CMD_SHED_LIMITS: rdata_next = {8'h00, shed_reg};
                `PSD_CMD_LOW_POWER: rdata_next = {6'h00, lp_reg};
                `PSD_CMD_LOAD_LINE: rdata_next = {9'h000, ll_reg};
                `PSD_CMD_FEATURES: rdata_next = {9'h000, feat_reg};
                `PSD_CMD_PWM_MID: rdata_next = {14'h0000, mid_reg};
                `PSD_CMD_LOCK: rdata_next = {14'h0000, lock_reg};
                `PSD_CMD_RISE_TUNE: rdata_next = {2'h0, rise_reg};
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    // reported phase count: live count while auto shedding runs
    assign phase_number_o = feat_reg[`PSD_B_AUTO] ? oper_phases_i
                                                  : phase_reg;

    // spacing between phase drops; a request inside the wait is simply
    // not granted, the loop keeps asking
    always_comb
    begin
        drop_cnt_next = drop_cnt_reg;
        grant_next = 1'b0;
        if (drop_cnt_reg != 18'h00000)
            drop_cnt_next = drop_cnt_reg - 18'h00001;
        else if (shed_req_i && feat_reg[`PSD_B_AUTO])
        begin
            grant_next = 1'b1;
            case (lp_reg[`PSD_F_DROP])
                2'h0: drop_cnt_next = 18'(DROP0_CYC - 1);
                2'h1: drop_cnt_next = 18'(DROP1_CYC - 1);
                2'h2: drop_cnt_next = 18'(DROP2_CYC - 1);
                default: drop_cnt_next = 18'(DROP3_CYC - 1);
            endcase
        end
    end
    assign shed_grant_o = grant_reg;

    // dither walks low, mid, high once per switching tick
    always_comb
    begin
        dith_next = dith_reg;
        dkhz_next = 8'sh00;
        if (feat_reg[`PSD_B_DITHER])
        begin
            if (sw_tick_i)
            begin
                case (dith_reg)
                    psd_pkg::PSD_DITH_LOW: dith_next = psd_pkg::PSD_DITH_MID;
                    psd_pkg::PSD_DITH_MID: dith_next = psd_pkg::PSD_DITH_HIGH;
                    default: dith_next = psd_pkg::PSD_DITH_LOW;
                endcase
            end
            case (dith_reg)
                psd_pkg::PSD_DITH_LOW: dkhz_next = -8'(`PSD_DITHER_KHZ);
                psd_pkg::PSD_DITH_MID: dkhz_next = 8'sh00;
                default: dkhz_next = 8'(`PSD_DITHER_KHZ);
            endcase
        end
        else
            dith_next = psd_pkg::PSD_DITH_LOW;
    end
    assign dither_khz_o = dkhz_reg;

    // decode of stored fields into loop settings
    always_comb
    begin
        cfg_next = '0;
        cfg_next.min_phases = {1'b0, shed_reg[`PSD_F_NMIN]} + 3'h1;
        case (shed_reg[`PSD_F_KFAC])
            2'h0: cfg_next.k_factor_x100 = 8'h7d;
            2'h1: cfg_next.k_factor_x100 = 8'h96;
            2'h2: cfg_next.k_factor_x100 = 8'haf;
            default: cfg_next.k_factor_x100 = 8'h64;
        endcase
        case (shed_reg[`PSD_F_HYS])
            2'h0: cfg_next.hys_pct_x10 = 10'h1f4;
            2'h1: cfg_next.hys_pct_x10 = 10'h0fa;
            2'h2: cfg_next.hys_pct_x10 = 10'h0a6;
            default: cfg_next.hys_pct_x10 = 10'h07d;
        endcase
        case (shed_reg[`PSD_F_I1])
            2'h0: cfg_next.i1_pct = 8'h64;
            2'h1: cfg_next.i1_pct = 8'h50;
            2'h2: cfg_next.i1_pct = 8'h5a;
            default: cfg_next.i1_pct = 8'h6e;
        endcase
        cfg_next.low_power_mode = lp_reg[`PSD_F_LPPS];
        cfg_next.low_power_phases = lp_reg[0] ? 3'h2 : 3'h1;
        cfg_next.freq_cap_code = lp_reg[5] ? 2'h2
                                           : {1'b0, lp_reg[4]};
        cfg_next.apa_tc_div = 4'h1 << lp_reg[`PSD_F_APA_TC];
        cfg_next.apa_delay_ns = 9'(lp_reg[`PSD_F_APA_DLY]
                                * `PSD_APA_STEP_NS);
        cfg_next.apa_delay_cyc = 4'(lp_reg[`PSD_F_APA_DLY]
                                 * `PSD_APA_STEP_CYC);
        cfg_next.droop_en = ll_reg[`PSD_B_DROOP];
        case (ll_reg[`PSD_F_NEG_LL])
            3'h0: cfg_next.neg_ll_pct = 7'h64;
            3'h1: cfg_next.neg_ll_pct = 7'h4b;
            3'h2: cfg_next.neg_ll_pct = 7'h32;
            3'h3: cfg_next.neg_ll_pct = 7'h19;
            default: cfg_next.neg_ll_pct = 7'h05;
        endcase
        cfg_next.pos_ll_en = ll_reg[`PSD_B_POS_LL];
        cfg_next.pos_ll_mv = 6'h04 << ll_reg[`PSD_F_POS_RANGE];
        // reference flag is synchronised, so boot refresh drops three cycles after the pin rises
        cfg_next.boot_refresh_on = feat_reg[`PSD_B_BOOT]
                                   && !pin_s2_reg[4];
        cfg_next.diode_emul_en = feat_reg[`PSD_B_DIODE];
        cfg_next.auto_shed_en = feat_reg[`PSD_B_AUTO];
        cfg_next.apa_level_mv = 7'(feat_reg[`PSD_F_APA_LVL]
                                * `PSD_APA_LVL_MV);
        cfg_next.mid_level_5v = mid_reg[`PSD_B_MID];
        cfg_next.allow_vid = (lock_reg == 2'h3);
        cfg_next.allow_small_ofs = (lock_reg != 2'h0);
        cfg_next.allow_large_ofs = lock_reg[1];
        cfg_next.rise_offset_mv = 9'(rise_reg[`PSD_F_RISE_OFS]
                                  * `PSD_RISE_STEP_MV);
    end
    assign cfg_o = cfg_reg;
    assign cmd_rdata_o = rdata_reg;
    assign cmd_rvalid_o = rvalid_reg;

    // state registers
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            phase_reg <= `PSD_RST_PHASE;
            shed_reg <= `PSD_RST_SHED;
            lp_reg <= `PSD_RST_LOW_POWER;
            ll_reg <= `PSD_RST_LOAD_LINE;
            feat_reg <= `PSD_RST_FEATURES;
            mid_reg <= `PSD_RST_PWM_MID;
            lock_reg <= `PSD_RST_LOCK;
            rise_reg <= `PSD_RST_RISE;
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
            drop_cnt_reg <= 18'h00000;
            grant_reg <= 1'b0;
            dith_reg <= psd_pkg::PSD_DITH_LOW;
            dkhz_reg <= 8'sh00;
            cfg_reg <= '0;
        end
        else
        begin
            phase_reg <= phase_next;
            shed_reg <= shed_next;
            lp_reg <= lp_next;
            ll_reg <= ll_next;
            feat_reg <= feat_next;
            mid_reg <= mid_next;
            lock_reg <= lock_next;
            rise_reg <= rise_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            drop_cnt_reg <= drop_cnt_next;
            grant_reg <= grant_next;
            dith_reg <= dith_next;
            dkhz_reg <= dkhz_next;
            cfg_reg <= cfg_next;
        end
    end

endmodule

// ### psd_config_bank_checker.sv
// port checker of the configuration bank
// bound to every psd_config_bank, watches its ports only
`timescale 1ns/10ps
module psd_config_bank_checker #(
    parameter int DROP3_CYC = 30000
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // strobes
    input wire logic cmd_wr_i,
    input wire logic nvm_load_i,
    // control loop side
    input wire logic [2:0] oper_phases_i,
    input wire logic ref_low_pin_i,
    input wire logic shed_grant_o,
    input wire logic [2:0] phase_number_o,
    input wire logic signed [7:0] dither_khz_o,
    input wire psd_pkg::psd_cfg_type cfg_o
);
    int gap_reg;
    int gap_next;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // cycles since last grant, saturating so it never wraps
    always_comb
    begin
        gap_next = gap_reg;
        if (shed_grant_o)
            gap_next = 0;
        else if (gap_reg < DROP3_CYC)
            gap_next = gap_reg + 1;
    end
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            gap_reg <= DROP3_CYC;
        else
            gap_reg <= gap_next;
    end
    // decode lags a write by one cycle, so skip the cycle after it
    chk_phase_report: assert property (cfg_o.auto_shed_en &&
        !$past(cmd_wr_i) && !$past(nvm_load_i) |->
        phase_number_o == oper_phases_i) else $error("phase report");
    chk_drop_gap: assert property (shed_grant_o |->
        gap_reg >= DROP3_CYC - 1 ##1 !shed_grant_o) else $error("drop gap");
    chk_dither_set: assert property (dither_khz_o inside
        {8'shf1, 8'sh00, 8'sh0f}) else $error("dither value");
    chk_apa_level: assert property (cfg_o.apa_level_mv inside
        {7'h00, 7'h0a, 7'h14, 7'h1e, 7'h28, 7'h32, 7'h3c, 7'h46})
        else $error("apa level");
    chk_boot_low: assert property (ref_low_pin_i[*4] |->
        !cfg_o.boot_refresh_on) else $error("boot refresh on");
    chk_lp_phases: assert property ($past(rst_b_i) |->
        cfg_o.low_power_phases == (cfg_o.low_power_mode[0] ? 3'h2 : 3'h1))
        else $error("low power phases");
    chk_tc_div: assert property ($past(rst_b_i) |->
        $onehot(cfg_o.apa_tc_div)) else $error("time constant");
    chk_delay_cyc: assert property (cfg_o.apa_delay_ns ==
        9'(cfg_o.apa_delay_cyc * 20)) else $error("stack delay");
    chk_lock_order: assert property (cfg_o.allow_vid |->
        cfg_o.allow_large_ofs && cfg_o.allow_small_ofs)
        else $error("lock order");
    // main scenarios
    cov_grant: cover property (shed_grant_o);
    cov_auto: cover property (cfg_o.auto_shed_en);
    cov_dither: cover property (dither_khz_o == 8'sh0f);
endmodule

bind psd_config_bank psd_config_bank_checker #(.DROP3_CYC(DROP3_CYC)) chk_i (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .cmd_wr_i(cmd_wr_i),
    .nvm_load_i(nvm_load_i), .oper_phases_i(oper_phases_i),
    .ref_low_pin_i(ref_low_pin_i), .shed_grant_o(shed_grant_o),
    .phase_number_o(phase_number_o), .dither_khz_o(dither_khz_o),
    .cfg_o(cfg_o)
);

// ### psd_host_model.sv
// host model: issues one whole command per strobe
// assumes the bank answers a read at the taking edge itself
`timescale 1ns/10ps
module psd_host_model (
    // clock and answer
    input wire logic mclk_i,
    input wire logic cmd_rvalid_i,
    input wire logic [15:0] cmd_rdata_i,
    // command
    output logic [7:0] cmd_code_o,
    output logic cmd_wr_o,
    output logic cmd_rd_o,
    output logic [15:0] cmd_wdata_o
);
    // idle bus at time zero
    initial
    begin
        cmd_code_o = 8'h00;
        cmd_wr_o = 1'b0;
        cmd_rd_o = 1'b0;
        cmd_wdata_o = 16'h0000;
    end
    // data inverted after the strobe so stale data never looks held
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(posedge mclk_i);
        #1;
        cmd_code_o = code;
        cmd_wdata_o = data;
        cmd_wr_o = 1'b1;
        @(posedge mclk_i);
        #1;
        cmd_wr_o = 1'b0;
        cmd_wdata_o = ~data;
    endtask
    // answer stands one cycle, taken right after the taking edge
    task automatic rd(input logic [7:0] code, output logic [15:0] data);
        @(posedge mclk_i);
        #1;
        cmd_code_o = code;
        cmd_rd_o = 1'b1;
        @(posedge mclk_i);
        #1;
        cmd_rd_o = 1'b0;
        data = cmd_rvalid_i ? cmd_rdata_i : 16'hdead;
    endtask
endmodule

// ### testbench.sv
// self-checking bench of the configuration bank
// host model drives commands, bench drives the loop side and pins
`timescale 1ns/10ps
`include "psd_defs.svh"
module testbench;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] code;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rvalid;
    logic nvm_load = 1'b0;
    psd_pkg::psd_nvm_type nvm_image = '0;
    logic [3:0] shed_pin = 4'h0;
    logic ref_low = 1'b0;
    logic shed_req = 1'b0;
    logic sw_tick = 1'b0;
    logic [2:0] oper_phases = 3'h4;
    logic hit;
    logic grant;
    logic [2:0] phase_number;
    logic signed [7:0] dither;
    psd_pkg::psd_cfg_type cfg;
    int n_errors = 0;
    int comparisons = 0;
    int n;
    logic [15:0] rv;
    logic [15:0] wmask [8] = '{16'h0007, 16'h00ff, 16'h03ff, 16'h007f,
        16'h007f, 16'h0003, 16'h0003, 16'h3fff};
    logic [15:0] k_tab [4] = '{16'h007d, 16'h0096, 16'h00af, 16'h0064};
    logic [15:0] h_tab [4] = '{16'h01f4, 16'h00fa, 16'h00a6, 16'h007d};
    logic [15:0] i_tab [4] = '{16'h0064, 16'h0050, 16'h005a, 16'h006e};
    logic [15:0] n_tab [5] = '{16'h0064, 16'h004b, 16'h0032, 16'h0019,
        16'h0005};
    logic [15:0] d_tab [4] = '{16'h00f1, 16'h0000, 16'h000f, 16'h00f1};
    int drop_tab [4] = '{40, 20, 10, 5};
    // short drop counts keep the run brief
    always #10 mclk_i = ~mclk_i;
    psd_config_bank #(.DROP0_CYC(40), .DROP1_CYC(20), .DROP2_CYC(10),
        .DROP3_CYC(5)) psd_config_bank_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .cmd_code_i(code), .cmd_wr_i(wr), .cmd_rd_i(rd), .cmd_wdata_i(wdata),
        .cmd_rdata_o(rdata), .cmd_rvalid_o(rvalid), .cmd_hit_o(hit),
        .nvm_load_i(nvm_load), .nvm_image_i(nvm_image), .shed_pin_i(shed_pin),
        .ref_low_pin_i(ref_low), .oper_phases_i(oper_phases),
        .shed_req_i(shed_req), .sw_tick_i(sw_tick), .shed_grant_o(grant),
        .phase_number_o(phase_number), .dither_khz_o(dither), .cfg_o(cfg));
    psd_host_model psd_host_model_i (.mclk_i(mclk_i), .cmd_rvalid_i(rvalid),
        .cmd_rdata_i(rdata), .cmd_code_o(code), .cmd_wr_o(wr),
        .cmd_rd_o(rd), .cmd_wdata_o(wdata));
    // shared compare, read-compare, settle and closing tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t seen %h expected %h",
                $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] c, input logic [15:0] exp);
        psd_host_model_i.rd(c, rv);
        check(rv, exp);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask
    task automatic wcfg(input logic [7:0] c, input logic [15:0] d);
        psd_host_model_i.wr(c, d);
        tick(1);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // whole run is a few hundred cycles
    initial
    begin
        #200us;
        n_errors++;
        test_done();
    end
    // main sequence
    initial
    begin
        tick(12);
        rst_b_i = 1'b1;
        rchk(`PSD_CMD_LOW_POWER, 16'h00c0);
        rchk(`PSD_CMD_LOCK, 16'h0000);
        check({15'h0000, hit}, 16'h0001);
        rchk(8'hc0, 16'h0000);
        check({15'h0000, hit}, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            psd_host_model_i.wr(8'hd0 + 8'(i), 16'hffff);
            rchk(8'hd0 + 8'(i), wmask[i]);
        end
        $display("test widths done");
        for (int c = 0; c < 4; c++)
        begin
            wcfg(`PSD_CMD_SHED_LIMITS, 16'(c * 85));
            check(cfg.min_phases, 16'(c + 1));
            check(cfg.k_factor_x100, k_tab[c]);
            check(cfg.hys_pct_x10, h_tab[c]);
            check(cfg.i1_pct, i_tab[c]);
            wcfg(`PSD_CMD_LOW_POWER, 16'(c * 341));
            check(cfg.low_power_mode, 16'(c));
            check(cfg.freq_cap_code, 16'(c > 1 ? 2 : c));
            check(cfg.apa_tc_div, 16'(1 << c));
            check(cfg.apa_delay_ns, 16'(c * 100));
            wcfg(`PSD_CMD_LOCK, 16'(c));
            check(cfg.allow_vid, 16'(c == 3));
            check(cfg.allow_large_ofs, 16'(c > 1));
            check(cfg.allow_small_ofs, 16'(c != 0));
        end
        for (int c = 0; c < 5; c++)
        begin
            wcfg(`PSD_CMD_LOAD_LINE, 16'(c % 4 * 32 + 16 + c * 2 + c % 2));
            check(cfg.droop_en, 16'(c % 2));
            check(cfg.neg_ll_pct, n_tab[c]);
            check(cfg.pos_ll_en, 16'h0001);
            check(cfg.pos_ll_mv, 16'(4 << (c % 4)));
        end
        for (int c = 0; c < 8; c++)
        begin
            wcfg(`PSD_CMD_FEATURES, 16'(c * 16 + 2));
            check(cfg.apa_level_mv, 16'(c * 10));
            check(cfg.diode_emul_en, 16'h0001);
            check(cfg.auto_shed_en, 16'h0000);
            wcfg(`PSD_CMD_RISE_TUNE, 16'(c * 9));
            check(cfg.rise_offset_mv, 16'(c * 45));
            wcfg(`PSD_CMD_PWM_MID, 16'(c % 2));
            check(cfg.mid_level_5v, 16'(c % 2));
        end
        $display("test decode done");
        wcfg(`PSD_CMD_FEATURES, 16'h0001);
        tick(4);
        check(cfg.boot_refresh_on, 16'h0001);
        ref_low = 1'b1;
        tick(4);
        check(cfg.boot_refresh_on, 16'h0000);
        ref_low = 1'b0;
        wcfg(`PSD_CMD_FEATURES, 16'h0008);
        tick(1);
        for (int j = 0; j < 4; j++)
        begin
            check({8'h00, dither}, d_tab[j]);
            sw_tick = 1'b1;
            tick(1);
            sw_tick = 1'b0;
            tick(1);
        end
        wcfg(`PSD_CMD_FEATURES, 16'h0000);
        tick(1);
        check({8'h00, dither}, 16'h0000);
        $display("test boot and dither done");
        wcfg(`PSD_CMD_PHASE_NUMBER, 16'h0003);
        rchk(`PSD_CMD_PHASE_NUMBER, 16'h0003);
        check(phase_number, 16'h0003);
        wcfg(`PSD_CMD_FEATURES, 16'h0004);
        check(cfg.auto_shed_en, 16'h0001);
        check(cfg.diode_emul_en, 16'h0000);
        wcfg(`PSD_CMD_PHASE_NUMBER, 16'h0006);
        check(phase_number, 16'h0004);
        // live count must follow the loop, refused write must not land
        oper_phases = 3'h2;
        tick(1);
        rchk(`PSD_CMD_PHASE_NUMBER, 16'h0002);
        wcfg(`PSD_CMD_FEATURES, 16'h0000);
        check(phase_number, 16'h0003);
        wcfg(`PSD_CMD_FEATURES, 16'h0004);
        for (int c = 0; c < 4; c++)
        begin
            wcfg(`PSD_CMD_LOW_POWER, 16'(c * 4));
            shed_req = 1'b1;
            n = 0;
            while (grant !== 1'b1 && n < 100)
            begin
                tick(1);
                n++;
            end
            n = 1;
            tick(1);
            while (grant !== 1'b1 && n < 100)
            begin
                tick(1);
                n++;
            end
            check(16'(n), 16'(drop_tab[c]));
            shed_req = 1'b0;
        end
        $display("test shedding done");
        nvm_image.load_line = 7'h55;
        nvm_image.low_power = 10'h001;
        shed_pin = 4'h6;
        tick(3);
        nvm_load = 1'b1;
        tick(1);
        nvm_load = 1'b0;
        tick(1);
        rchk(`PSD_CMD_LOAD_LINE, 16'h0055);
        check(cfg.min_phases, 16'h0002);
        check(cfg.k_factor_x100, k_tab[2]);
        check(cfg.hys_pct_x10, h_tab[1]);
        $display("test bank load done");
        test_done();
    end
endmodule
